//--- hw/ltf_params.svh
// Constants for the line driver float, fault and termination control block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef LTF_PARAMS_SVH
`define LTF_PARAMS_SVH

// Register indices inside one link window (byte address = index * 4)
`define LTF_REG_GCTRL   8'h0f
`define LTF_REG_PROT    8'h20
`define LTF_REG_PULSE   8'h23
`define LTF_REG_SCALE   8'h24
`define LTF_REG_TERM    8'h32
`define LTF_REG_IEN0    8'h33
`define LTF_REG_IEN1    8'h34
`define LTF_REG_EDGE    8'h35
`define LTF_REG_LSTAT   8'h36
`define LTF_REG_IFLG0   8'h3a
`define LTF_REG_IFLG1   8'h3b
`define LTF_REG_TIMING  8'h70

// Bit positions
`define LTF_B_DRVEN     0
`define LTF_B_SRST      1
`define LTF_B_SPE       0
`define LTF_B_TXFLOAT   4
`define LTF_B_DF        0
`define LTF_B_DAC       0
`define LTF_B_XTS       0
`define LTF_B_MASTER    1
`define LTF_B_RLB       2
`define LTF_B_PDN       3
`define LTF_B_TEXT      2

// Reset values
`define LTF_RST_REG     8'h00
`define LTF_RST_SCALE   8'h04

// Pulse select code of the -22.5 dB build-out template
`define LTF_LBO_M22P5   4'h7

// Timing and arithmetic
`define LTF_BP_LOSS_CYC 7'h48
`define LTF_DUTY_LO     16'h001e
`define LTF_DUTY_HI     16'h0046
`define LTF_DUTY_DEN    16'h0064
`define LTF_SCALE_SHIFT 2
`define LTF_SAMPLE_MAX  13'h007f

// Template, sample 1 of UI 1 in the low bits, 7 bits per sample
`define LTF_TPL_M22P5 { \
  7'h01,7'h01,7'h01,7'h01,7'h02,7'h02,7'h02,7'h03, \
  7'h03,7'h04,7'h04,7'h05,7'h05,7'h06,7'h07,7'h08, \
  7'h09,7'h0a,7'h0c,7'h0d,7'h0e,7'h0f,7'h10,7'h11, \
  7'h13,7'h14,7'h15,7'h17,7'h18,7'h1a,7'h1c,7'h1e, \
  7'h20,7'h22,7'h24,7'h27,7'h29,7'h2c,7'h2e,7'h30, \
  7'h31,7'h32,7'h32,7'h32,7'h31,7'h30,7'h2e,7'h2c, \
  7'h2a,7'h27,7'h23,7'h20,7'h1c,7'h19,7'h15,7'h0f, \
  7'h0b,7'h07,7'h03,7'h01,7'h00,7'h00,7'h00,7'h00 }

`endif

//--- hw/ltf_pkg.sv
// Types for the line driver float, fault and termination control block.
// Assumes the constants header is on the include path.
`default_nettype none
`include "ltf_params.svh"

package ltf_pkg;

  // Per-link registers and link-facing state
  typedef struct packed {
    logic [7:0] protCfg;
    logic [7:0] pulseCfg;
    logic [7:0] ampScale;
    logic [7:0] termCfg;
    logic [7:0] irqEnZero;
    logic [7:0] irqEnOne;
    logic [7:0] edgeSel;
    logic [7:0] lineState;
    logic [7:0] flagsZero;
    logic [7:0] flagsOne;
    logic [7:0] timingOpt;
    logic [3:0] bpSync;
    logic [3:0] faultSync;
    logic [6:0] bpIdle;
    logic [6:0] sample;
    logic       drvOe;
  } ltf_link_state_type;

  // Whole block state
  typedef struct packed {
    ltf_link_state_type [1:0] lk;
    logic                     drvGate;
    logic                     softRst;
    logic [3:0]               pinSync;
    logic [3:0]               oscSync;
    logic [7:0]               oscHi;
    logic [7:0]               oscLo;
    logic                     oscBad;
    logic [7:0]               div;
    logic                     wbAck;
    logic [31:0]              wbDat;
    logic                     irq;
  } ltf_state_type;

endpackage
`default_nettype wire

//--- hw/ltf_line_ctrl.sv
// Line driver float, short fault and termination control for two links.
// Assumes a classic Wishbone master on mclk and asynchronous pin inputs.
//
// Functional notes
// RQ1 - Global float pin high floats both line drivers together.
// RQ2 - Missing or badly skewed reference oscillator floats both drivers.
// RQ3 - After any reset both drivers stay floated.
// RQ4 - Per-link float bit floats only that link's driver.
// RQ5 - Master mode, source select 1: lost recovered clock floats driver.
// RQ6 - Slave mode, source select 0: backplane idle over 72 cycles floats.
// RQ7 - Remote loopback suppresses the backplane loss float.
// RQ8 - Transmit power-down floats that link's driver.
// RQ9 - Any float condition floats the driver without waiting for a boundary.
// RQ10 - Short protection enable limits current and reports driver fault state.
// RQ11 - Fault flag set on rising edge or either edge per edge select.
// RQ12 - Fault flag with its enable drives the interrupt request.
// RQ13 - Amplitude overflow sets its flag and may interrupt.
// RQ14 - -22.5 dB template nominal scale 000100, each step 25 percent.
// RQ15 - -22.5 dB template is four UI of sixteen 7-bit samples.
// RQ16 - T1/J1 termination uses low bits for internal matching.
// RQ17 - E1 termination bit 2 set disables internal matching.
// RQ18 - Flags stay until cleared; interrupt ORs enabled set flags.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "ltf_params.svh"

module ltf_line_ctrl
  import ltf_pkg::*;
#(
  parameter logic [7:0] LINE_DIV  = 8'h10,
  parameter logic [7:0] OSC_STUCK = 8'hc8
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Wishbone slave
  input  wire logic [10:0] wbAdrI,
  input  wire logic [31:0] wbDatI,
  input  wire logic [3:0]  wbSelI,
  input  wire logic        wbWeI,
  input  wire logic        wbCycI,
  input  wire logic        wbStbI,
  output logic [31:0]      wbDatO,
  output logic             wbAckO,
  // Asynchronous pins
  input  wire logic        globalDriverFloatPin,
  input  wire logic        referenceOscInput,
  input  wire logic [1:0]  backplaneClk,
  // Link status from transmit and receive logic
  input  wire logic [1:0]  recClkLost,
  input  wire logic [1:0]  drvOverCurrent,
  input  wire logic [1:0]  ampOverflowIn,
  input  wire logic [11:0] txSampleIdx,
  // Driver and termination controls
  output logic [1:0]       lineOutOe,
  output logic [1:0]       shortProtectEn,
  output logic [5:0]       txTermSel,
  output logic [1:0]       txTermInternal,
  output logic [13:0]      txSample,
  output logic             intReq
);

  localparam logic [447:0] TPL = `LTF_TPL_M22P5;

  ltf_state_type st;
  ltf_state_type n;
  ltf_state_type rstVal;

  logic        hit;
  logic        wrNow;
  logic [8:0]  period;
  logic        ackKeep;
  logic [31:0] datKeep;
  logic [1:0]  bpLost;
  logic [1:0]  faultNow;
  logic [1:0]  faultEvt;
  logic [1:0]  ampEvt;
  logic [1:0]  tplMatch;
  logic [1:0]  ampOvf;
  logic [1:0]  floatCond;
  logic [6:0]  rawSample [2];
  logic [12:0] prod [2];
  logic        tick;

  // Three-stage synchroniser; level moves once stages two and three agree
  function automatic logic [3:0] ltf_sync(input logic [3:0] c,
                                          input logic d);
    logic lvl;
    lvl = (c[2] == c[1]) ? c[2] : c[3];
    return {lvl, c[1:0], d};
  endfunction

  // Accepted level change of a synchroniser
  function automatic logic ltf_chg(input logic [3:0] c);
    return (c[2] == c[1]) && (c[2] != c[3]);
  endfunction

  // Register read decode
  function automatic logic [7:0] ltf_rd(input ltf_state_type s,
                                        input logic [8:0] idx);
    ltf_link_state_type l;
    logic [7:0] r;
    l = s.lk[idx[8]];
    r = 8'h00;
    case (idx[7:0])
      `LTF_REG_GCTRL:  r = idx[8] ? 8'h00 : {7'h00, s.drvGate};
      `LTF_REG_PROT:   r = l.protCfg;
      `LTF_REG_PULSE:  r = l.pulseCfg;
      `LTF_REG_SCALE:  r = l.ampScale;
      `LTF_REG_TERM:   r = l.termCfg;
      `LTF_REG_IEN0:   r = l.irqEnZero;
      `LTF_REG_IEN1:   r = l.irqEnOne;
      `LTF_REG_EDGE:   r = l.edgeSel;
      `LTF_REG_LSTAT:  r = l.lineState;
      `LTF_REG_IFLG0:  r = l.flagsZero;
      `LTF_REG_IFLG1:  r = l.flagsOne;
      `LTF_REG_TIMING: r = l.timingOpt;
      default:         r = 8'h00;
    endcase
    return r;
  endfunction

  // Reset image: drivers floated, oscillator unproven
  always_comb begin
    rstVal = '0;
    rstVal.oscBad = 1'b1;
    for (int i = 0; i < 2; i++) begin
      rstVal.lk[i].protCfg   = `LTF_RST_REG;
      rstVal.lk[i].ampScale  = `LTF_RST_SCALE;
      rstVal.lk[i].termCfg   = `LTF_RST_REG;
      rstVal.lk[i].timingOpt = `LTF_RST_REG;
    end
  end

  // Next-state logic
  always_comb begin
    n = st;
    period = 9'h000;
    ackKeep = 1'b0;
    datKeep = 32'h00000000;

    // Bus slave: ack one cycle after the request, write at the ack edge
    hit = wbCycI & wbStbI;
    wrNow = hit & st.wbAck & wbWeI & wbSelI[0];
    n.wbAck = hit & ~st.wbAck;
    if (hit & ~st.wbAck) begin
      n.wbDat = {24'h000000, ltf_rd(st, wbAdrI[10:2])};
    end
    n.softRst = 1'b0;
    if (wrNow && (wbAdrI[10:2] == {1'b0, `LTF_REG_GCTRL})) begin
      n.drvGate = wbDatI[`LTF_B_DRVEN];
      n.softRst = wbDatI[`LTF_B_SRST];
    end

    // Line-rate enable for the backplane idle count
    tick = (st.div == LINE_DIV - 8'h01);
    n.div = tick ? 8'h00 : st.div + 8'h01;

    // Pins
    n.pinSync = ltf_sync(st.pinSync, globalDriverFloatPin);
    n.oscSync = ltf_sync(st.oscSync, referenceOscInput);

    // Oscillator duty check at each rising edge, stuck check on the cycles between edges
    if (ltf_chg(st.oscSync) && st.oscSync[2]) begin
      period = {1'b0, st.oscHi} + {1'b0, st.oscLo};
      n.oscBad = ({8'h00, st.oscHi} * `LTF_DUTY_DEN <
                  {7'h00, period} * `LTF_DUTY_LO) ||
                 ({8'h00, st.oscHi} * `LTF_DUTY_DEN >
                  {7'h00, period} * `LTF_DUTY_HI);           // [RQ2]
      n.oscHi = 8'h00;
      n.oscLo = 8'h00;
    end else begin
      if (st.oscSync[3] && st.oscHi != OSC_STUCK) begin
        n.oscHi = st.oscHi + 8'h01;
      end
      if (!st.oscSync[3] && st.oscLo != OSC_STUCK) begin
        n.oscLo = st.oscLo + 8'h01;
      end
      if (st.oscHi == OSC_STUCK || st.oscLo == OSC_STUCK) begin
        n.oscBad = 1'b1;                                      // [RQ2]
      end
    end

    n.irq = 1'b0;
    for (int i = 0; i < 2; i++) begin
      // Backplane clock activity
      n.lk[i].bpSync = ltf_sync(st.lk[i].bpSync, backplaneClk[i]);
      bpLost[i] = st.lk[i].bpIdle > `LTF_BP_LOSS_CYC;         // [RQ6]
      if (ltf_chg(st.lk[i].bpSync)) begin
        n.lk[i].bpIdle = 7'h00;
      end else if (tick && !bpLost[i]) begin
        n.lk[i].bpIdle = st.lk[i].bpIdle + 7'h01;
      end

      // Driver fault state only counts while protection is on
      n.lk[i].faultSync = ltf_sync(st.lk[i].faultSync, drvOverCurrent[i]);
      faultNow[i] = st.lk[i].faultSync[3] &
                    st.lk[i].protCfg[`LTF_B_SPE];             // [RQ10]
      n.lk[i].lineState[`LTF_B_DF] = faultNow[i];
      faultEvt[i] = st.lk[i].edgeSel[`LTF_B_DF] ?
                    (faultNow[i] != st.lk[i].lineState[`LTF_B_DF]) :
                    (faultNow[i] & ~st.lk[i].lineState[`LTF_B_DF]); // [RQ11]

      // Template sample scaled by code/4, saturated at full scale
      rawSample[i] = TPL[{3'b000, txSampleIdx[i*6 +: 6]} * 9'h7 +: 7]; // [RQ15]
      prod[i] = {6'h00, rawSample[i]} * {7'h00, st.lk[i].ampScale[5:0]};
      ampOvf[i] = (prod[i] >> `LTF_SCALE_SHIFT) > `LTF_SAMPLE_MAX;
      tplMatch[i] = st.lk[i].pulseCfg[3:0] == `LTF_LBO_M22P5;
      if (!tplMatch[i]) begin
        n.lk[i].sample = 7'h00;
      end else if (ampOvf[i]) begin
        n.lk[i].sample = 7'h7f;
      end else begin
        n.lk[i].sample = prod[i][`LTF_SCALE_SHIFT +: 7];       // [RQ14]
      end
      ampEvt[i] = ampOverflowIn[i] | (tplMatch[i] & ampOvf[i]); // [RQ13]

      // Register writes; flag bits clear by writing one
      if (wrNow && wbAdrI[10] == 1'(i)) begin
        case (wbAdrI[9:2])
          `LTF_REG_PROT:   n.lk[i].protCfg   = wbDatI[7:0];
          `LTF_REG_PULSE:  n.lk[i].pulseCfg  = wbDatI[7:0];
          `LTF_REG_SCALE:  n.lk[i].ampScale  = {2'b00, wbDatI[5:0]};
          `LTF_REG_TERM:   n.lk[i].termCfg   = {5'h00, wbDatI[2:0]};
          `LTF_REG_IEN0:   n.lk[i].irqEnZero = wbDatI[7:0];
          `LTF_REG_IEN1:   n.lk[i].irqEnOne  = wbDatI[7:0];
          `LTF_REG_EDGE:   n.lk[i].edgeSel   = wbDatI[7:0];
          `LTF_REG_IFLG0:  n.lk[i].flagsZero = st.lk[i].flagsZero &
                                               ~wbDatI[7:0];
          `LTF_REG_IFLG1:  n.lk[i].flagsOne  = st.lk[i].flagsOne &
                                               ~wbDatI[7:0];
          `LTF_REG_TIMING: n.lk[i].timingOpt = wbDatI[7:0];
          default: ;
        endcase
      end

      // Events set after the clear so a same-cycle event is kept
      if (faultEvt[i]) begin
        n.lk[i].flagsZero[`LTF_B_DF] = 1'b1;                  // [RQ11] [RQ18]
      end
      if (ampEvt[i]) begin
        n.lk[i].flagsOne[`LTF_B_DAC] = 1'b1;                  // [RQ13] [RQ18]
      end
      if (|(st.lk[i].flagsZero & st.lk[i].irqEnZero) ||
          |(st.lk[i].flagsOne & st.lk[i].irqEnOne)) begin
        n.irq = 1'b1;                                         // [RQ12] [RQ18]
      end

      // Float decision; no frame alignment, next edge drops the enable
      floatCond[i] =
        st.pinSync[3] |                                        // [RQ1]
        st.oscBad |                                            // [RQ2]
        ~st.drvGate |                                          // [RQ3]
        st.lk[i].pulseCfg[`LTF_B_TXFLOAT] |                    // [RQ4]
        (st.lk[i].timingOpt[`LTF_B_MASTER] &
         st.lk[i].timingOpt[`LTF_B_XTS] & recClkLost[i]) |     // [RQ5]
        (~st.lk[i].timingOpt[`LTF_B_MASTER] &
         ~st.lk[i].timingOpt[`LTF_B_XTS] & bpLost[i] &
         ~st.lk[i].timingOpt[`LTF_B_RLB]) |                    // [RQ6] [RQ7]
        st.lk[i].timingOpt[`LTF_B_PDN];                        // [RQ8]
      n.lk[i].drvOe = ~floatCond[i];                           // [RQ9]
    end

    // Software reset clears everything but the bus answer
    if (st.softRst) begin
      ackKeep = n.wbAck;
      datKeep = n.wbDat;
      n = rstVal;                                             // [RQ3]
      n.wbAck = ackKeep;
      n.wbDat = datKeep;
    end
  end

  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st <= rstVal;                                           // [RQ3]
    end else begin
      st <= n;
    end
  end

  // Outputs straight from the state register
  assign wbDatO = st.wbDat;
  assign wbAckO = st.wbAck;
  assign intReq = st.irq;
  generate
    for (genvar g = 0; g < 2; g++) begin : gOut
      assign lineOutOe[g]      = st.lk[g].drvOe;
      assign shortProtectEn[g] = st.lk[g].protCfg[`LTF_B_SPE];
      // Internal match unless E1 external bit; T1/J1 keeps it clear
      assign txTermInternal[g] = ~st.lk[g].termCfg[`LTF_B_TEXT]; // [RQ17]
      assign txTermSel[g*3 +: 3] = st.lk[g].termCfg[2:0];        // [RQ16]
      assign txSample[g*7 +: 7] = st.lk[g].sample;
    end
  endgenerate

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_pin_float_both: assert property ( // [RQ1]
    st.pinSync[3] |=> lineOutOe == 2'b00)
    else $error("float pin did not float both drivers");

  a_osc_float_both: assert property ( // [RQ2]
    st.oscBad && !st.softRst |=> lineOutOe == 2'b00)
    else $error("bad oscillator did not float drivers");

  a_reset_hold_float: assert property ( // [RQ3]
    $rose(rst_n) |-> lineOutOe == 2'b00 ##1 lineOutOe == 2'b00)
    else $error("driver active right after reset");

  a_link_float_own: assert property ( // [RQ4]
    st.lk[0].pulseCfg[`LTF_B_TXFLOAT] && !st.softRst |=> !lineOutOe[0])
    else $error("link float bit ignored");

  a_rec_loss_float: assert property ( // [RQ5]
    st.lk[0].timingOpt[`LTF_B_MASTER] && st.lk[0].timingOpt[`LTF_B_XTS]
    && recClkLost[0] |=> !lineOutOe[0])
    else $error("recovered clock loss did not float");

  a_bp_loss_float: assert property ( // [RQ6]
    st.lk[0].bpIdle > `LTF_BP_LOSS_CYC && st.lk[0].timingOpt[3:0] == 4'h0
    |=> !lineOutOe[0])
    else $error("backplane loss did not float");

  a_loopback_keeps: assert property ( // [RQ7]
    st.drvGate && !st.oscBad && !st.pinSync[3] && !st.softRst &&
    st.lk[0].timingOpt[3:0] == 4'h4 &&
    !st.lk[0].pulseCfg[`LTF_B_TXFLOAT] |=> lineOutOe[0])
    else $error("remote loopback driver floated");

  a_pwrdn_float: assert property ( // [RQ8]
    st.lk[0].timingOpt[`LTF_B_PDN] && !st.softRst |=> !lineOutOe[0])
    else $error("power-down did not float");

  a_fault_state: assert property ( // [RQ10]
    !st.lk[0].protCfg[`LTF_B_SPE] && !st.softRst
    |=> !st.lk[0].lineState[`LTF_B_DF])
    else $error("fault state without protection");

  a_fault_flag_set: assert property ( // [RQ11]
    faultEvt[0] |=> st.lk[0].flagsZero[`LTF_B_DF] || $past(st.softRst))
    else $error("fault event lost");

  a_irq_follows: assert property ( // [RQ12]
    (|(st.lk[0].flagsZero & st.lk[0].irqEnZero)) |=> intReq)
    else $error("enabled flag gave no interrupt");

  a_irq_quiet: assert property ( // [RQ18]
    !(|(st.lk[0].flagsZero & st.lk[0].irqEnZero)) &&
    !(|(st.lk[0].flagsOne & st.lk[0].irqEnOne)) &&
    !(|(st.lk[1].flagsZero & st.lk[1].irqEnZero)) &&
    !(|(st.lk[1].flagsOne & st.lk[1].irqEnOne)) |=> !intReq)
    else $error("interrupt without enabled flag");

  a_amp_flag_set: assert property ( // [RQ13]
    ampOverflowIn[1] && !st.softRst |=> st.lk[1].flagsOne[`LTF_B_DAC])
    else $error("amplitude overflow lost");

  a_scale_nominal: assert property ( // [RQ14]
    tplMatch[0] && st.lk[0].ampScale == `LTF_RST_SCALE && !st.softRst
    |=> txSample[6:0] == $past(rawSample[0]))
    else $error("nominal scale changed the sample");

endmodule
`default_nettype wire

//--- tb/ltf_line_model.sv
// Line cable model standing behind the two transmit line drivers.
// Assumes the bench moves its fault commands just after rising mclk.
`timescale 1ns/100ps
`default_nettype none

module ltf_line_model (
  // Clock
  input  wire logic       mclk,
  // Driver side
  input  wire logic [1:0] lineOutOe,
  // Bench commands: shorted pair, cut receive line
  input  wire logic [1:0] shortOn,
  input  wire logic [1:0] cutOn,
  // What the cable reflects back into the device
  output logic [1:0]      drvOverCurrent,
  output logic [1:0]      recClkLost
);
  // A shorted pair only draws current while its driver is live,
  // so floating the driver must make the fault go away
  always_ff @(posedge mclk) begin
    drvOverCurrent <= shortOn & lineOutOe;
    recClkLost     <= cutOn;
  end
endmodule
`default_nettype wire

//--- tb/tb_ltf_line_ctrl.sv
// Self-checking bench for the line driver float and fault control.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ltf_params.svh"

module tb_ltf_line_ctrl;
  logic        mclk, rst_n, wbWeI, wbCycI, wbStbI, wbAckO, intReq;
  logic        globalDriverFloatPin, referenceOscInput, oscRun, oscSkew;
  logic [10:0] wbAdrI;
  logic [31:0] wbDatI, wbDatO;
  logic [3:0]  wbSelI;
  logic [1:0]  backplaneClk, bpRun, recClkLost, drvOverCurrent;
  logic [1:0]  ampOverflowIn, shortOn, cutOn, lineOutOe;
  logic [1:0]  shortProtectEn, txTermInternal;
  logic [11:0] txSampleIdx;
  logic [5:0]  txTermSel;
  logic [13:0] txSample;
  logic [2:0]  div;
  logic [7:0]  rd;
  int          errTotal, totalChecks;

  // Short counts keep the oscillator and backplane checks quick
  ltf_line_ctrl #(.LINE_DIV(8'h02), .OSC_STUCK(8'h14)) u_ltf_line_ctrl (
    .mclk(mclk), .rst_n(rst_n), .wbAdrI(wbAdrI), .wbDatI(wbDatI),
    .wbSelI(wbSelI), .wbWeI(wbWeI), .wbCycI(wbCycI), .wbStbI(wbStbI),
    .wbDatO(wbDatO), .wbAckO(wbAckO),
    .globalDriverFloatPin(globalDriverFloatPin),
    .referenceOscInput(referenceOscInput), .backplaneClk(backplaneClk),
    .recClkLost(recClkLost), .drvOverCurrent(drvOverCurrent),
    .ampOverflowIn(ampOverflowIn), .txSampleIdx(txSampleIdx),
    .lineOutOe(lineOutOe), .shortProtectEn(shortProtectEn),
    .txTermSel(txTermSel), .txTermInternal(txTermInternal),
    .txSample(txSample), .intReq(intReq));

  ltf_line_model u_ltf_line_model (
    .mclk(mclk), .lineOutOe(lineOutOe), .shortOn(shortOn), .cutOn(cutOn),
    .drvOverCurrent(drvOverCurrent), .recClkLost(recClkLost));

  // 25 MHz system clock
  always #20 mclk = ~mclk;

  // Reference at 50 % duty, 25 % when skewed; backplane clocks faster;
  // stopped ones sit low
  always @(posedge mclk) begin
    div               <= div + 3'h1;
    referenceOscInput <= oscRun & (oscSkew ? &div[2:1] : div[2]);
    backplaneClk      <= bpRun & {2{div[1]}};
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    totalChecks++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // One classic cycle; held until ack is sampled, then a gap cycle
  task automatic bus(input logic l, input logic [7:0] idx, input logic we,
                     input logic [7:0] d);
    int n;
    n = 0;
    wbAdrI <= {l, idx, 2'b00};
    wbWeI  <= we;
    wbDatI <= {24'h000000, d};
    wbSelI <= 4'hf;
    wbCycI <= 1'b1;
    wbStbI <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (wbAckO !== 1'b1 && n < 20);
    chk("bus ack", 8'h01, 8'(wbAckO));
    rd = wbDatO[7:0];
    wbCycI <= 1'b0;
    wbStbI <= 1'b0;
    wbWeI  <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wr(input logic l, input logic [7:0] idx, input logic [7:0] d);
    bus(l, idx, 1'b1, d);
  endtask

  task automatic rdChk(input logic l, input logic [7:0] idx,
                       input logic [7:0] e, input string nm);
    bus(l, idx, 1'b0, 8'h00);
    chk(nm, e, rd);
  endtask

  task automatic waitOe(input logic [1:0] e, input int lim, input string nm);
    int n;
    n = 0;
    while (lineOutOe !== e && n < lim) begin
      @(posedge mclk);
      n++;
    end
    chk(nm, 8'(e), 8'(lineOutOe));
  endtask

  task automatic tReset;
    chk("oe after reset", 8'h00, 8'(lineOutOe));
    chk("term internal", 8'h03, 8'(txTermInternal));
    chk("term select reset", 8'h00, 8'(txTermSel));
    rdChk(1'b0, `LTF_REG_SCALE, 8'h04, "scale reset");
    rdChk(1'b0, 8'h7f, 8'h00, "unmapped read");
    wr(1'b0, `LTF_REG_GCTRL, 8'h01);
    waitOe(2'b11, 60, "enabled");
  endtask

  task automatic tPins;
    globalDriverFloatPin <= 1'b1;
    waitOe(2'b00, 8, "pin float");
    globalDriverFloatPin <= 1'b0;
    waitOe(2'b11, 8, "pin release");
    oscRun <= 1'b0;
    tick(10);
    chk("osc not yet stuck", 8'h03, 8'(lineOutOe));
    waitOe(2'b00, 30, "osc stuck");
    oscRun <= 1'b1;
    waitOe(2'b11, 60, "osc back");
    oscSkew <= 1'b1;
    waitOe(2'b00, 40, "osc duty low");
    oscSkew <= 1'b0;
    waitOe(2'b11, 60, "osc duty back");
  endtask

  task automatic tLinkBits;
    wr(1'b1, `LTF_REG_PULSE, 8'h10);
    waitOe(2'b01, 4, "link float bit");
    wr(1'b1, `LTF_REG_PULSE, 8'h00);
    waitOe(2'b11, 4, "link float off");
    wr(1'b0, `LTF_REG_TIMING, 8'h08);
    waitOe(2'b10, 4, "power down");
    wr(1'b0, `LTF_REG_TIMING, 8'h00);
    waitOe(2'b11, 4, "power up");
  endtask

  task automatic tClocks;
    cutOn <= 2'b10;
    tick(6);
    chk("cut in slave mode", 8'h03, 8'(lineOutOe));
    cutOn <= 2'b00;
    wr(1'b0, `LTF_REG_TIMING, 8'h03);
    cutOn <= 2'b01;
    waitOe(2'b10, 5, "recovered lost");
    cutOn <= 2'b00;
    waitOe(2'b11, 5, "recovered back");
    wr(1'b0, `LTF_REG_TIMING, 8'h00);
    bpRun <= 2'b10;
    tick(130);
    chk("backplane short idle", 8'h03, 8'(lineOutOe));
    waitOe(2'b10, 40, "backplane lost");
    wr(1'b0, `LTF_REG_TIMING, 8'h04);
    waitOe(2'b11, 4, "remote loopback");
    wr(1'b0, `LTF_REG_TIMING, 8'h00);
    bpRun <= 2'b11;
    waitOe(2'b11, 20, "backplane back");
  endtask

  task automatic tFault;
    wr(1'b0, `LTF_REG_IEN0, 8'h01);
    shortOn <= 2'b01;
    tick(12);
    rdChk(1'b0, `LTF_REG_LSTAT, 8'h00, "fault unprotected");
    wr(1'b0, `LTF_REG_PROT, 8'h01);
    tick(12);
    chk("protect enable", 8'h01, 8'(shortProtectEn));
    rdChk(1'b0, `LTF_REG_LSTAT, 8'h01, "fault state");
    chk("fault irq", 8'h01, 8'(intReq));
    wr(1'b0, `LTF_REG_IFLG0, 8'h01);
    shortOn <= 2'b00;
    tick(12);
    rdChk(1'b0, `LTF_REG_IFLG0, 8'h00, "rising only");
    chk("irq cleared", 8'h00, 8'(intReq));
    wr(1'b0, `LTF_REG_EDGE, 8'h01);
    shortOn <= 2'b01;
    tick(12);
    wr(1'b0, `LTF_REG_IFLG0, 8'h01);
    shortOn <= 2'b00;
    tick(12);
    rdChk(1'b0, `LTF_REG_IFLG0, 8'h01, "both edges");
    wr(1'b0, `LTF_REG_IEN0, 8'h00);
    tick(3);
    chk("fault masked", 8'h00, 8'(intReq));
    wr(1'b0, `LTF_REG_IFLG0, 8'h01);
  endtask

  task automatic tTemplate;
    int sc[4];
    int e;
    sc = '{4, 5, 3, 12};
    txSampleIdx <= 12'h015;
    wr(1'b0, `LTF_REG_PULSE, 8'h07);
    wr(1'b0, `LTF_REG_IEN1, 8'h01);
    for (int i = 0; i < 4; i++) begin
      wr(1'b0, `LTF_REG_SCALE, 8'(sc[i]));
      tick(3);
      // UI 2 sample 6 of the -22.5 dB template is 50; a step is 25 %
      e = (50 * sc[i]) >> 2;
      if (e > 127) e = 127;
      chk("scaled sample", 8'(e), 8'(txSample[6:0]));
    end
    // Link 1 has no template selected, so its sample stays at zero
    chk("link1 sample", 8'h00, 8'(txSample[13:7]));
    rdChk(1'b0, `LTF_REG_IFLG1, 8'h01, "overflow flag");
    chk("overflow irq", 8'h01, 8'(intReq));
    wr(1'b0, `LTF_REG_SCALE, 8'h04);
    wr(1'b0, `LTF_REG_IFLG1, 8'h01);
    wr(1'b1, `LTF_REG_IEN1, 8'h01);
    tick(3);
    chk("overflow cleared", 8'h00, 8'(intReq));
    ampOverflowIn <= 2'b10;
    tick(1);
    ampOverflowIn <= 2'b00;
    tick(3);
    rdChk(1'b1, `LTF_REG_IFLG1, 8'h01, "link1 overflow");
    chk("link1 irq", 8'h01, 8'(intReq));
  endtask

  task automatic tTermSoft;
    for (int c = 0; c < 4; c++) begin
      wr(1'b1, `LTF_REG_TERM, 8'(c));
      tick(2);
      chk("term select", 8'(c), 8'(txTermSel[5:3]));
      chk("term internal", 8'h01, 8'(txTermInternal[1]));
    end
    wr(1'b1, `LTF_REG_TERM, 8'h05);
    tick(2);
    chk("term external", 8'h00, 8'(txTermInternal[1]));
    wr(1'b0, `LTF_REG_GCTRL, 8'h02);
    tick(2);
    chk("soft reset oe", 8'h00, 8'(lineOutOe));
    chk("soft reset irq", 8'h00, 8'(intReq));
    rdChk(1'b1, `LTF_REG_TERM, 8'h00, "soft reset term");
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence: quiet inputs, three cycles of reset, then scenarios
  initial begin
    {mclk, rst_n, wbWeI, wbCycI, wbStbI, globalDriverFloatPin} = 6'h00;
    {wbAdrI, wbDatI, wbSelI, txSampleIdx} = 59'h0;
    {bpRun, oscRun, div} = 6'h38;
    {shortOn, cutOn, ampOverflowIn} = 6'h00;
    oscSkew = 1'b0;
    errTotal = 0;
    totalChecks = 0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    tReset();
    tPins();
    tLinkBits();
    tClocks();
    tFault();
    tTemplate();
    tTermSoft();
    conclude();
  end

  // Watchdog: the scenarios need well under this many cycles
  initial begin
    repeat (6000) @(posedge mclk);
    errTotal++;
    conclude();
  end
endmodule
`default_nettype wire
